// ### mdss_operator_model.sv
`timescale 1ns/1ns
module mdss_operator_model (
    // clock
    input wire logic clk,
    // remote inputs
    output logic goRequest,
    output logic goBackward,
    output logic inchRequest,
    output logic haltLatchN,
    // keypad
    output logic keyRun,
    output logic keyStop,
    output logic keyInch,
    output logic keyDir,
    // forced halts
    output logic quickHaltN,
    output logic freewheelHaltN
);
    // idle levels: no request, halts released
    initial begin
        {goRequest, goBackward, inchRequest, keyRun, keyStop, keyInch, keyDir} = 7'h00;
        {haltLatchN, quickHaltN, freewheelHaltN} = 3'h7;
    end

    // remote levels change just after an edge
    task automatic set_remote(input logic go, input logic back, input logic inch);
        @(posedge clk);
        #1;
        goRequest = go;
        goBackward = back;
        inchRequest = inch;
    endtask

    // forced halt inputs, active low
    task automatic set_forced(input logic qh, input logic fw);
        @(posedge clk);
        #1;
        quickHaltN = qh;
        freewheelHaltN = fw;
    endtask

    // keypad key level: 0 run, 1 stop, 2 inch, 3 direction
    task automatic key(input int k, input logic v);
        @(posedge clk);
        #1;
        case (k)
            0: keyRun = v;
            1: keyStop = v;
            3: keyDir = v;
            default: keyInch = v;
        endcase
    endtask

    task automatic halt_pulse(input int cyc);
        @(posedge clk);
        #1;
        haltLatchN = 1'b0;
        repeat (cyc) @(posedge clk);
        #1;
        haltLatchN = 1'b1;
    endtask
endmodule

// ### mdss_pkg.sv
package mdss_pkg;
    localparam int VEL_W = 16;
    localparam int PER_W = 16;
    localparam logic [PER_W-1:0] FINAL_PERIOD_RST = 16'h2710; // 10.0 s in 1 ms ticks
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int LATCH_MS = 100;
    localparam int LATCH_TICKS = LATCH_MS * 1000 / TICK_US;
    localparam logic [1:0] WIRE_ONE = 2'h0;
    localparam logic [1:0] WIRE_TWO = 2'h1;
    localparam logic [1:0] WIRE_THREE = 2'h2;
    localparam logic [1:0] HALT_RAMP_FINAL = 2'h0;
    localparam logic [1:0] HALT_FREEWHEEL = 2'h1;
    localparam logic [1:0] HALT_RAMP_QUICK = 2'h2;
    typedef enum logic [2:0] {
        MDSS_IDLE, MDSS_RUN, MDSS_INCH, MDSS_FALL, MDSS_FINAL, MDSS_HOLD
    } mdss_state_t;
endpackage

// ### mdss_sequencer.sv
`timescale 1ns/1ns
module mdss_sequencer #(
    parameter int TICK_CYCLES = mdss_pkg::TICK_CYC,
    parameter int LATCH_COUNT = mdss_pkg::LATCH_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // source selection, 1 = local keypad
    input wire logic startLocal,
    input wire logic speedLocal,
    // remote inputs
    input wire logic goRequest,
    input wire logic goBackward,
    input wire logic inchRequest,
    input wire logic haltLatchN,
    input wire logic [1:0] wireScheme,
    // keypad
    input wire logic keyRun,
    input wire logic keyStop,
    input wire logic keyInch,
    input wire logic keyDir,
    // forced halts, trip, permit
    input wire logic quickHaltN,
    input wire logic freewheelHaltN,
    input wire logic tripPresent,
    input wire logic tripReset,
    input wire logic stackPermit,
    input wire logic rampFreeze,
    // references and settings
    input wire logic [mdss_pkg::VEL_W-1:0] remoteReference,
    input wire logic [mdss_pkg::VEL_W-1:0] keypadReference,
    input wire logic [mdss_pkg::VEL_W-1:0] inchTarget,
    input wire logic [mdss_pkg::VEL_W-1:0] velocityAdjust,
    input wire logic [mdss_pkg::PER_W-1:0] riseRampPeriod,
    input wire logic [mdss_pkg::PER_W-1:0] inchRisePeriod,
    input wire logic [mdss_pkg::PER_W-1:0] fallRampPeriod,
    input wire logic [mdss_pkg::PER_W-1:0] finalRampPeriod,
    input wire logic [mdss_pkg::PER_W-1:0] quickHaltPeriod,
    input wire logic [mdss_pkg::PER_W-1:0] stackHoldDelay,
    input wire logic [1:0] haltMethodSelect,
    input wire logic [1:0] quickHaltMethod,
    // outputs
    output logic [mdss_pkg::VEL_W-1:0] velocityCommand,
    output logic [mdss_pkg::VEL_W-1:0] velocityAdjustOut,
    output logic backwardOut,
    output logic stackEnable,
    output logic activeFlag,
    output logic faultFreeFlag
);
    import mdss_pkg::*;

    // refuse counts the dividers cannot serve
    if (TICK_CYCLES < 1 || LATCH_COUNT < 1) begin : gBadParam
        $error("tick and latch counts must be at least one");
    end

    mdss_state_t state_r, state_nxt;
    logic [31:0] tickCnt_r;
    logic tick_r;
    logic [VEL_W-1:0] vel_r, vel_nxt, adj_r, adj_nxt;
    logic [PER_W-1:0] holdCnt_r;
    logic [31:0] latchCnt_r;
    logic stopLatched_r, keyLatch_r, wireLatch_r, dir_r, tripped_r, stack_r, active_r;
    logic [VEL_W-1:0] velOut_r, adjOut_r;
    logic fault_free_flag_r;

    // control tick divider
    always_ff @(posedge clk) begin
        if (!resetn || tickCnt_r == 32'(TICK_CYCLES - 1)) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + 32'h00000001;
        end
    end
    always_ff @(posedge clk) begin
        tick_r <= resetn && tickCnt_r == 32'(TICK_CYCLES - 1);
    end

    // start request decode per wiring scheme
    wire bothRemote = goRequest && goBackward;
    wire remoteTwo = (goRequest || goBackward) && !bothRemote;
    wire remoteGo = (wireScheme == WIRE_ONE) ? goRequest :
                    (wireScheme == WIRE_TWO) ? remoteTwo : wireLatch_r;
    wire remoteDir = (wireScheme == WIRE_ONE) ? 1'b0 :
                     (wireScheme == WIRE_THREE) ? dir_r : goBackward;
    wire runReq = startLocal ? keyLatch_r : remoteGo;
    wire inchReq = startLocal ? keyInch : inchRequest;
    wire [VEL_W-1:0] reference = speedLocal ? keypadReference : remoteReference;
    wire freeStop = tripped_r || tripPresent || !freewheelHaltN;
    wire quickStop = !freeStop && !quickHaltN;
    wire runGo = runReq && quickHaltN && !stopLatched_r;
    wire inchGo = inchReq && quickHaltN;
    wire rampHalt = quickStop ? (quickHaltMethod != HALT_FREEWHEEL)
                              : (haltMethodSelect != HALT_FREEWHEEL);
    wire [PER_W-1:0] finalPer = (quickStop || haltMethodSelect == HALT_RAMP_QUICK) ?
                                quickHaltPeriod : finalRampPeriod;

    // keypad run latch and three-wire latch
    // local run latch
    wire keyLatchNxt = (keyLatch_r || (keyRun && stackPermit)) && !keyStop && quickHaltN;
    // three-wire latch gated by halt input
    wire wireLatchNxt = haltLatchN && wireScheme == WIRE_THREE &&
                        (wireLatch_r || goRequest || goBackward);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            keyLatch_r <= 1'b0;
            wireLatch_r <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            keyLatch_r <= keyLatchNxt;
            wireLatch_r <= wireLatchNxt;
            dir_r <= goBackward ? 1'b1 : (goRequest ? 1'b0 : dir_r);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            latchCnt_r <= '0;
            stopLatched_r <= 1'b0;
        end else begin
            if (haltLatchN) begin
                latchCnt_r <= '0;
            end else if (tick_r && latchCnt_r < 32'(LATCH_COUNT)) begin
                latchCnt_r <= latchCnt_r + 32'h00000001;
            end
            if (!haltLatchN && latchCnt_r >= 32'(LATCH_COUNT) && wireScheme == WIRE_THREE) begin
                stopLatched_r <= 1'b1;
            end else if (state_r == MDSS_IDLE && haltLatchN) begin
                stopLatched_r <= 1'b0;
            end
        end
    end

    // trip held until reset after clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tripped_r <= 1'b0;
        end else if (tripPresent) begin
            tripped_r <= 1'b1;
        end else if (tripReset) begin
            tripped_r <= 1'b0;
        end
    end

    // linear slope step for a period
    function automatic logic [VEL_W-1:0] stepOf(input logic [PER_W-1:0] per);
        logic [VEL_W-1:0] s;
        s = (per == '0) ? {VEL_W{1'b1}} : VEL_W'({VEL_W{1'b1}} / per);
        return (s == '0) ? VEL_W'(1) : s;
    endfunction
    function automatic logic [VEL_W-1:0] toward(input logic [VEL_W-1:0] cur,
        input logic [VEL_W-1:0] tgt, input logic [VEL_W-1:0] st);
        if (cur < tgt) begin
            return (tgt - cur > st) ? VEL_W'(cur + st) : tgt;
        end else begin
            return (cur - tgt > st) ? VEL_W'(cur - st) : tgt;
        end
    endfunction

    // sequencing state machine
    always_comb begin
        state_nxt = state_r;
        vel_nxt = vel_r;
        adj_nxt = adj_r;
        case (state_r)
            MDSS_IDLE: begin
                vel_nxt = '0;
                adj_nxt = '0;
                // permit gates start; one at a time
                if (!freeStop && stackPermit && runGo) begin
                    state_nxt = MDSS_RUN;
                end else if (!freeStop && stackPermit && inchGo) begin
                    state_nxt = MDSS_INCH;
                end
            end
            MDSS_RUN, MDSS_INCH: begin
                adj_nxt = velocityAdjust;
                if (tick_r) begin
                    vel_nxt = (state_r == MDSS_RUN) ?
                        toward(vel_r, reference, stepOf(riseRampPeriod)) :
                        toward(vel_r, inchTarget, stepOf(inchRisePeriod));
                end
                if (freeStop || (quickStop && !rampHalt) ||
                    (!quickStop && !rampHalt && !(state_r == MDSS_RUN ? runGo : inchGo))) begin
                    state_nxt = MDSS_IDLE;
                    vel_nxt = '0;
                end else if (quickStop || !(state_r == MDSS_RUN ? runGo : inchGo)) begin
                    // zero fall period or freeze skips fall
                    state_nxt = (fallRampPeriod == '0 || rampFreeze || quickStop) ?
                                MDSS_FINAL : MDSS_FALL;
                end
            end
            MDSS_FALL: begin
                if (tick_r) begin
                    vel_nxt = toward(vel_r, '0, stepOf(fallRampPeriod));
                end
                if (vel_r == '0) begin
                    state_nxt = MDSS_FINAL;
                end
            end
            MDSS_FINAL: begin
                // final ramp of command and adjust
                if (tick_r) begin
                    vel_nxt = toward(vel_r, '0, stepOf(finalPer));
                    adj_nxt = toward(adj_r, '0, stepOf(finalPer));
                end
                if (vel_r == '0 && adj_r == '0) begin
                    state_nxt = MDSS_HOLD;
                end
            end
            MDSS_HOLD: begin
                if (holdCnt_r >= stackHoldDelay) begin
                    state_nxt = MDSS_IDLE;
                end
            end
            default: begin
                state_nxt = MDSS_IDLE;
            end
        endcase
        if (freeStop && state_r != MDSS_IDLE) begin
            state_nxt = MDSS_IDLE;
            vel_nxt = '0;
            adj_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= MDSS_IDLE;
            vel_r <= '0;
            adj_r <= '0;
        end else begin
            state_r <= state_nxt;
            vel_r <= vel_nxt;
            adj_r <= adj_nxt;
        end
    end

    // hold delay tick counter
    always_ff @(posedge clk) begin
        if (!resetn || state_r != MDSS_HOLD) begin
            holdCnt_r <= '0;
        end else if (tick_r && holdCnt_r != {PER_W{1'b1}}) begin
            holdCnt_r <= holdCnt_r + 16'h0001;
        end
    end

    // registered outputs
    // active and fault free flags
    always_ff @(posedge clk) begin
        if (!resetn) begin
            velOut_r <= '0;
            adjOut_r <= '0;
            stack_r <= 1'b0;
            active_r <= 1'b0;
            fault_free_flag_r <= 1'b0;
            backwardOut <= 1'b0;
        end else begin
            velOut_r <= vel_nxt;
            adjOut_r <= adj_nxt;
            stack_r <= state_nxt != MDSS_IDLE && stackPermit;
            active_r <= state_nxt != MDSS_IDLE;
            fault_free_flag_r <= !(tripped_r || tripPresent);
            backwardOut <= startLocal ? keyDir : remoteDir;
        end
    end
    assign velocityCommand = velOut_r;
    assign velocityAdjustOut = adjOut_r;
    assign stackEnable = stack_r;
    assign activeFlag = active_r;
    assign faultFreeFlag = fault_free_flag_r;

    // checks
    freewheel_off_a: assert property (@(posedge clk) disable iff (!resetn)
        !freewheelHaltN |=> !stackEnable && velocityCommand == '0)
        else $error("freewheel halt left stack on");
    trip_off_a: assert property (@(posedge clk) disable iff (!resetn)
        tripPresent |=> !stackEnable ##1 !stackEnable)
        else $error("trip left stack on");
    fault_free_flag_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        tripPresent |=> !faultFreeFlag)
        else $error("fault free flag wrong under trip");
    permit_start_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == MDSS_IDLE && !stackPermit |=> state_r == MDSS_IDLE)
        else $error("started without permit");
    active_stack_a: assert property (@(posedge clk) disable iff (!resetn)
        stackEnable |-> activeFlag)
        else $error("stack on while not active");
    quick_block_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == MDSS_IDLE && !quickHaltN |=> state_r == MDSS_IDLE)
        else $error("start during quick halt");
    hold_stack_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == MDSS_HOLD && holdCnt_r < stackHoldDelay && !freeStop |=> stackEnable || !stackPermit)
        else $error("stack dropped before hold delay");
    inch_nolatch_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == MDSS_INCH && !inchGo && !rampHalt && !freeStop |=> state_r == MDSS_IDLE)
        else $error("inch continued after release");
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import mdss_pkg::*;
    localparam int TCK = 4;
    localparam int LCNT = 3;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic startLocal = 1'b0;
    logic speedLocal = 1'b0;
    logic [1:0] wireScheme = WIRE_ONE;
    logic tripPresent = 1'b0;
    logic tripReset = 1'b0;
    logic stackPermit = 1'b0;
    logic rampFreeze = 1'b0;
    logic [1:0] haltMethodSelect = HALT_RAMP_FINAL;
    logic [1:0] quickHaltMethod = HALT_RAMP_QUICK;
    logic [15:0] remoteReference = 16'h8000, keypadReference = 16'h4000;
    logic [15:0] inchTarget = 16'h2000, velocityAdjust = 16'h0000;
    logic [15:0] riseRampPeriod = 16'h0004, inchRisePeriod = 16'h0004;
    logic [15:0] fallRampPeriod = 16'h0004, finalRampPeriod = 16'h0004;
    logic [15:0] quickHaltPeriod = 16'h0002, stackHoldDelay = 16'h0002;
    logic goRequest, goBackward, inchRequest, haltLatchN;
    logic keyRun, keyStop, keyInch, keyDir, quickHaltN, freewheelHaltN;
    logic [15:0] velocityCommand, velocityAdjustOut;
    logic backwardOut, stackEnable, activeFlag, faultFreeFlag;
    int n_fail = 0;
    int cmp_count = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    // block under test and operator model
    mdss_sequencer #(.TICK_CYCLES(TCK), .LATCH_COUNT(LCNT)) dut (
        .clk, .resetn, .startLocal, .speedLocal, .goRequest, .goBackward,
        .inchRequest, .haltLatchN, .wireScheme, .keyRun, .keyStop, .keyInch,
        .keyDir, .quickHaltN, .freewheelHaltN, .tripPresent, .tripReset,
        .stackPermit, .rampFreeze, .remoteReference, .keypadReference,
        .inchTarget, .velocityAdjust, .riseRampPeriod, .inchRisePeriod,
        .fallRampPeriod, .finalRampPeriod, .quickHaltPeriod, .stackHoldDelay,
        .haltMethodSelect, .quickHaltMethod, .velocityCommand,
        .velocityAdjustOut, .backwardOut, .stackEnable, .activeFlag, .faultFreeFlag);
    mdss_operator_model op (
        .clk, .goRequest, .goBackward, .inchRequest, .haltLatchN, .keyRun,
        .keyStop, .keyInch, .keyDir, .quickHaltN, .freewheelHaltN);

    // shared compare, wait and close
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // mode 0: command equals v, mode 1: stopped and stack off
    task automatic wait_for(input int mode, input logic [15:0] v);
        for (int i = 0; i < 400; i++) begin
            cyc(1);
            if (mode == 0 && velocityCommand === v) return;
            if (mode == 1 && activeFlag === 1'b0 && stackEnable === 1'b0) return;
        end
        n_fail++;
        $display("ERROR %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic run_up();
        op.set_remote(1'b1, 1'b0, 1'b0);
        wait_for(0, remoteReference);
    endtask

    // scenarios
    task automatic t_reset();
        cyc(20);
        chk(16'({activeFlag, stackEnable, faultFreeFlag}), 16'h0000);
        chk(velocityCommand, 16'h0000);
        resetn = 1'b1;
        cyc(2);
        chk(16'(faultFreeFlag), 16'h0001);
        $display("test reset done");
    endtask
    task automatic t_remote_run();
        op.set_remote(1'b1, 1'b0, 1'b0);
        cyc(3);
        chk(16'(activeFlag), 16'h0000);
        stackPermit = 1'b1;
        cyc(2);
        chk(16'({activeFlag, stackEnable}), 16'h0003);
        wait_for(0, remoteReference);
        cyc(2 * TCK);
        chk(velocityCommand, remoteReference);
        op.set_remote(1'b0, 1'b0, 1'b0);
        cyc(TCK + 2);
        chk(16'(activeFlag), 16'h0001);
        wait_for(0, 16'h0000);
        chk(16'(stackEnable), 16'h0001);
        wait_for(1, 16'h0000);
        $display("test remote run done");
    endtask
    task automatic t_freewheel();
        haltMethodSelect = HALT_FREEWHEEL;
        run_up();
        op.set_remote(1'b0, 1'b0, 1'b0);
        cyc(2);
        chk(velocityCommand, 16'h0000);
        chk(16'(stackEnable), 16'h0000);
        op.set_remote(1'b0, 1'b0, 1'b1);
        wait_for(0, inchTarget);
        op.set_remote(1'b0, 1'b0, 1'b0);
        cyc(2);
        chk(16'({activeFlag, stackEnable}), 16'h0000);
        chk(velocityCommand, 16'h0000);
        haltMethodSelect = HALT_RAMP_FINAL;
        run_up();
        op.set_forced(1'b0, 1'b0);
        cyc(2);
        chk(16'({activeFlag, stackEnable}), 16'h0000);
        op.set_remote(1'b0, 1'b0, 1'b0);
        op.set_forced(1'b1, 1'b1);
        $display("test freewheel done");
    endtask
    task automatic t_quick();
        run_up();
        op.set_forced(1'b0, 1'b1);
        cyc(TCK + 2);
        chk(16'(velocityCommand < remoteReference), 16'h0001);
        wait_for(1, 16'h0000);
        cyc(3 * TCK);
        chk(16'(activeFlag), 16'h0000);
        op.set_remote(1'b0, 1'b0, 1'b0);
        op.set_forced(1'b1, 1'b1);
        quickHaltMethod = HALT_FREEWHEEL;
        run_up();
        op.set_forced(1'b0, 1'b1);
        cyc(2);
        chk(16'({activeFlag, stackEnable}), 16'h0000);
        chk(velocityCommand, 16'h0000);
        op.set_remote(1'b0, 1'b0, 1'b0);
        op.set_forced(1'b1, 1'b1);
        quickHaltMethod = HALT_RAMP_QUICK;
        $display("test quick halt done");
    endtask
    task automatic t_stop_modes();
        rampFreeze = 1'b1;
        finalRampPeriod = 16'h0008;
        velocityAdjust = 16'h1000;
        run_up();
        chk(velocityAdjustOut, 16'h1000);
        op.set_remote(1'b0, 1'b0, 1'b0);
        wait_for(0, 16'h6001);
        wait_for(1, 16'h0000);
        chk(velocityAdjustOut, 16'h0000);
        rampFreeze = 1'b0;
        fallRampPeriod = 16'h0000;
        haltMethodSelect = HALT_RAMP_QUICK;
        run_up();
        op.set_remote(1'b0, 1'b0, 1'b0);
        wait_for(0, 16'h0001);
        wait_for(1, 16'h0000);
        haltMethodSelect = HALT_RAMP_FINAL;
        fallRampPeriod = 16'h0004;
        finalRampPeriod = 16'h0004;
        velocityAdjust = 16'h0000;
        $display("test stop modes done");
    endtask
    task automatic t_trip();
        run_up();
        tripPresent = 1'b1;
        cyc(2);
        chk(16'({faultFreeFlag, stackEnable}), 16'h0000);
        chk(velocityCommand, 16'h0000);
        tripPresent = 1'b0;
        cyc(4);
        chk(16'(activeFlag), 16'h0000);
        tripReset = 1'b1;
        cyc(1);
        tripReset = 1'b0;
        cyc(3);
        chk(16'({faultFreeFlag, activeFlag}), 16'h0003);
        op.set_remote(1'b0, 1'b0, 1'b0);
        wait_for(1, 16'h0000);
        $display("test trip done");
    endtask
    task automatic t_wires();
        wireScheme = WIRE_TWO;
        op.set_remote(1'b0, 1'b1, 1'b0);
        wait_for(0, remoteReference);
        chk(16'(backwardOut), 16'h0001);
        op.set_remote(1'b1, 1'b1, 1'b0);
        wait_for(1, 16'h0000);
        wireScheme = WIRE_THREE;
        op.set_remote(1'b1, 1'b0, 1'b0);
        op.set_remote(1'b0, 1'b0, 1'b0);
        cyc(2 * TCK);
        chk(16'(activeFlag), 16'h0001);
        op.halt_pulse((LCNT + 1) * TCK + 2);
        wait_for(1, 16'h0000);
        op.set_remote(1'b0, 1'b0, 1'b1);
        wait_for(0, inchTarget);
        op.set_remote(1'b0, 1'b0, 1'b0);
        wait_for(1, 16'h0000);
        wireScheme = WIRE_ONE;
        $display("test wiring schemes done");
    endtask
    task automatic t_local();
        startLocal = 1'b1;
        speedLocal = 1'b1;
        op.key(3, 1'b1);
        op.key(0, 1'b1);
        op.key(0, 1'b0);
        wait_for(0, keypadReference);
        chk(16'(backwardOut), 16'h0001);
        op.key(2, 1'b1);
        cyc(2 * TCK);
        chk(velocityCommand, keypadReference);
        op.key(2, 1'b0);
        op.key(1, 1'b1);
        op.key(1, 1'b0);
        wait_for(1, 16'h0000);
        op.key(3, 1'b0);
        startLocal = 1'b0;
        op.set_remote(1'b1, 1'b0, 1'b0);
        wait_for(0, keypadReference);
        chk(16'(backwardOut), 16'h0000);
        op.set_remote(1'b0, 1'b0, 1'b0);
        wait_for(1, 16'h0000);
        speedLocal = 1'b0;
        $display("test local keypad done");
    endtask

    // main sequence
    initial begin
        t_reset();
        t_remote_run();
        t_freewheel();
        t_quick();
        t_stop_modes();
        t_trip();
        t_wires();
        t_local();
        report_and_stop();
    end
endmodule
